//--- cbr_pkg.sv
// constants for the clock buffer upper configuration bank and its smbus target
// assumes scl and sda arrive already synchronous to clk
package cbr_pkg;
  // ************************************************
  // register indices
  // ************************************************
  localparam logic [7:0] IDX_FEEDBACK_RATE = 8'h03;
  localparam logic [7:0] IDX_RSVD = 8'h04;
  localparam logic [7:0] IDX_REV_MAKER = 8'h05;
  localparam logic [7:0] IDX_PART = 8'h06;
  localparam logic [7:0] IDX_READ_LEN = 8'h07;

  // ************************************************
  // fields and reset values
  // ************************************************
  localparam int FEEDBACK_RATE_BIT = 0;
  localparam logic FEEDBACK_RATE_RESET = 1'b1;
  localparam logic [7:0] FEEDBACK_RATE_RSVD_BITS = 8'h82;
  localparam logic [7:0] RSVD_VALUE = 8'hff;
  localparam int READ_LEN_WIDTH = 5;
  localparam logic [4:0] READ_LEN_RESET = 5'h08;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

  // ************************************************
  // bus constants
  // ************************************************
  localparam logic [6:0] SMB_ADDR_DEFAULT = 7'h50;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;

  typedef enum logic [2:0] {
    CBR_IDLE,
    CBR_ADDR,
    CBR_INDEX,
    CBR_WCOUNT,
    CBR_WDATA,
    CBR_RDATA,
    CBR_WAIT
  } cbr_state_t;
endpackage

//--- cbr_regs.sv
// byte-indexed register bank for bytes 3 to 7
// assumes one write strobe per accepted data byte from the bus target
`timescale 1ns/1ps
module cbr_regs #(
  parameter logic [3:0] REVISION = 4'h3,   // arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h9, // arbitrary value
  parameter logic [1:0] PART_CLASS = 2'h2, // arbitrary value
  parameter logic [5:0] PART_IDENT = 6'h15 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_idx,
  output logic [7:0] rd_data,
  output logic feedback_edge_rate_select,
  output logic [4:0] read_length
);
  // ************************************************
  // writable fields
  // ************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feedback_edge_rate_select <= cbr_pkg::FEEDBACK_RATE_RESET;
    end else if (wr_en && wr_idx == cbr_pkg::IDX_FEEDBACK_RATE) begin
      feedback_edge_rate_select <= wr_data[cbr_pkg::FEEDBACK_RATE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      read_length <= cbr_pkg::READ_LEN_RESET;
    end else if (wr_en && wr_idx == cbr_pkg::IDX_READ_LEN) begin
      read_length <= wr_data[cbr_pkg::READ_LEN_WIDTH-1:0];
    end
  end

  // ************************************************
  // read mux, fixed fields ignore writes
  // ************************************************
  always_comb begin
    case (rd_idx)
      cbr_pkg::IDX_FEEDBACK_RATE: begin
        rd_data = cbr_pkg::FEEDBACK_RATE_RSVD_BITS | {7'h00, feedback_edge_rate_select};
      end
      cbr_pkg::IDX_RSVD: begin
        rd_data = cbr_pkg::RSVD_VALUE;
      end
      cbr_pkg::IDX_REV_MAKER: begin
        rd_data = {REVISION, MAKER_CODE};
      end
      cbr_pkg::IDX_PART: begin
        rd_data = {PART_CLASS, PART_IDENT};
      end
      cbr_pkg::IDX_READ_LEN: begin
        rd_data = {3'h0, read_length};
      end
      default: begin
        rd_data = cbr_pkg::UNMAPPED_VALUE;
      end
    endcase
  end
endmodule

//--- cbr_top.sv
// smbus target serving the upper configuration bytes by block read and write
// assumes scl_in and sda_in are synchronous to clk and much slower than it
`timescale 1ns/1ps
module cbr_top #(
  parameter logic [6:0] SMB_ADDR = cbr_pkg::SMB_ADDR_DEFAULT,
  parameter logic [3:0] REVISION = 4'h3,   // arbitrary value
  parameter logic [3:0] MAKER_CODE = 4'h9, // arbitrary value
  parameter logic [1:0] PART_CLASS = 2'h2, // arbitrary value
  parameter logic [5:0] PART_IDENT = 6'h15 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic feedback_edge_rate_select,
  output logic [4:0] read_length
);
  // ************************************************
  // elaboration checks
  // ************************************************
  if (SMB_ADDR == 7'h00) begin : g_bad_addr
    $error("general call address cannot be the target address");
  end

  // ************************************************
  // bus edge and condition detection
  // ************************************************
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end

  assign scl_rise = scl_in && !scl_d;
  assign scl_fall = !scl_in && scl_d;
  assign start_cond = scl_in && scl_d && sda_d && !sda_in;
  assign stop_cond = scl_in && scl_d && !sda_d && sda_in;

  // ************************************************
  // state
  // ************************************************
  cbr_pkg::cbr_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [7:0] index;
  logic [7:0] wr_left;
  logic [4:0] rd_left;
  logic ack_ok;
  logic drive_low;
  logic [7:0] rd_data;
  logic wr_en;
  logic byte_done;
  logic ack_done;
  logic addr_hit;
  logic seen_rise;

  assign byte_done = scl_fall && bit_cnt == cbr_pkg::BIT_LAST;
  assign ack_done = scl_fall && bit_cnt == cbr_pkg::BIT_ACK;
  assign addr_hit = rx_byte[7:1] == SMB_ADDR;
  // one write per accepted data byte, counted by the host's byte count
  assign wr_en = byte_done && state == cbr_pkg::CBR_WDATA && wr_left != 8'h00;

  cbr_regs #(
    .REVISION(REVISION),
    .MAKER_CODE(MAKER_CODE),
    .PART_CLASS(PART_CLASS),
    .PART_IDENT(PART_IDENT)
  ) u_regs (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(wr_en),
    .wr_idx(index),
    .wr_data(rx_byte),
    .rd_idx(index),
    .rd_data(rd_data),
    .feedback_edge_rate_select(feedback_edge_rate_select),
    .read_length(read_length)
  );

  // ************************************************
  // bit counter and receive shifter
  // ************************************************
  // the clock fall that follows a start is not a bit boundary
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_rise <= 1'b0;
    end else if (start_cond || stop_cond) begin
      seen_rise <= 1'b0;
    end else if (scl_rise) begin
      seen_rise <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= 4'h0;
    end else if (start_cond || stop_cond) begin
      bit_cnt <= 4'h0;
    end else if (ack_done) begin
      bit_cnt <= 4'h0;
    end else if (scl_fall && seen_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_byte <= 8'h00;
    end else if (scl_rise && bit_cnt < cbr_pkg::BIT_ACK) begin
      rx_byte <= {rx_byte[6:0], sda_in};
    end
  end

  // ************************************************
  // transaction sequencing
  // ************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= cbr_pkg::CBR_IDLE;
    end else if (start_cond) begin
      state <= cbr_pkg::CBR_ADDR;
    end else if (stop_cond) begin
      state <= cbr_pkg::CBR_IDLE;
    end else begin
      case (state)
        cbr_pkg::CBR_ADDR: begin
          if (byte_done && !addr_hit) begin
            state <= cbr_pkg::CBR_WAIT;
          end else if (ack_done) begin
            state <= rx_byte[0] ? cbr_pkg::CBR_RDATA : cbr_pkg::CBR_INDEX;
          end
        end
        cbr_pkg::CBR_INDEX: begin
          if (ack_done) begin
            state <= cbr_pkg::CBR_WCOUNT;
          end
        end
        cbr_pkg::CBR_WCOUNT: begin
          if (ack_done) begin
            state <= cbr_pkg::CBR_WDATA;
          end
        end
        cbr_pkg::CBR_WDATA: begin
          if (byte_done && !ack_ok && wr_left == 8'h00) begin
            state <= cbr_pkg::CBR_WAIT;
          end
        end
        cbr_pkg::CBR_RDATA: begin
          // host not-acknowledge ends the read
          if (scl_rise && bit_cnt == cbr_pkg::BIT_ACK && sda_in) begin
            state <= cbr_pkg::CBR_WAIT;
          end
        end
        cbr_pkg::CBR_IDLE, cbr_pkg::CBR_WAIT: begin
          state <= state;
        end
        default: begin
          state <= cbr_pkg::CBR_IDLE;
        end
      endcase
    end
  end

  // acknowledge decision at the end of each received byte
  always_comb begin
    case (state)
      cbr_pkg::CBR_ADDR: begin
        ack_ok = addr_hit;
      end
      cbr_pkg::CBR_INDEX, cbr_pkg::CBR_WCOUNT: begin
        ack_ok = 1'b1;
      end
      cbr_pkg::CBR_WDATA: begin
        ack_ok = wr_left != 8'h00;
      end
      default: begin
        ack_ok = 1'b0;
      end
    endcase
  end

  // ************************************************
  // index, write count and read count
  // ************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      index <= 8'h00;
    end else if (byte_done && state == cbr_pkg::CBR_INDEX) begin
      index <= rx_byte;
    end else if (wr_en) begin
      index <= index + 8'h01;
    end else if (ack_done && state == cbr_pkg::CBR_RDATA && rd_left != 5'h00) begin
      index <= index + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_left <= 8'h00;
    end else if (byte_done && state == cbr_pkg::CBR_WCOUNT) begin
      wr_left <= rx_byte;
    end else if (wr_en) begin
      wr_left <= wr_left - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_left <= 5'h00;
    end else if (ack_done && state == cbr_pkg::CBR_ADDR) begin
      rd_left <= read_length;
    end else if (ack_done && state == cbr_pkg::CBR_RDATA && rd_left != 5'h00) begin
      rd_left <= rd_left - 5'h01;
    end
  end

  // ************************************************
  // transmit shifter and sda drive
  // ************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_byte <= 8'hff;
    end else if (ack_done && state == cbr_pkg::CBR_ADDR) begin
      tx_byte <= {3'h0, read_length};
    end else if (ack_done && state == cbr_pkg::CBR_RDATA) begin
      // past the programmed length the bus idles high
      tx_byte <= (rd_left != 5'h00) ? rd_data : 8'hff;
    end else if (scl_fall && state == cbr_pkg::CBR_RDATA && bit_cnt < cbr_pkg::BIT_LAST) begin
      tx_byte <= {tx_byte[6:0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_low <= 1'b0;
    end else if (start_cond || stop_cond) begin
      drive_low <= 1'b0;
    end else if (byte_done) begin
      drive_low <= ack_ok;
    end else if (ack_done && state == cbr_pkg::CBR_ADDR) begin
      drive_low <= rx_byte[0] && !read_length[4];
    end else if (ack_done && state == cbr_pkg::CBR_RDATA) begin
      drive_low <= (rd_left != 5'h00) && !rd_data[7];
    end else if (ack_done) begin
      drive_low <= 1'b0;
    end else if (scl_fall && state == cbr_pkg::CBR_RDATA && bit_cnt < cbr_pkg::BIT_LAST) begin
      drive_low <= !tx_byte[6];
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
endmodule

//--- cbr_host.sv
// smbus host model driving scl and resolving the open-drain data line
// assumes the device pulls data low while dev_oe is high
`timescale 1ns/1ps
module cbr_host (
  input wire logic clk,
  input wire logic dev_oe,
  output logic scl,
  output logic sda
);
  logic pull_low;

  // released line floats high through the pull-up
  assign sda = !(pull_low || dev_oe);

  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end

  // one bus phase of ten clocks, changes made on the falling edge
  task automatic sl(input logic c, input logic d);
    scl = c;
    pull_low = d;
    repeat (10) @(negedge clk);
  endtask

  // also serves as repeated start
  task automatic start;
    sl(1'b0, 1'b0);
    sl(1'b1, 1'b0);
    sl(1'b1, 1'b1);
    sl(1'b0, 1'b1);
  endtask

  task automatic stop;
    sl(1'b0, 1'b1);
    sl(1'b1, 1'b1);
    sl(1'b1, 1'b0);
  endtask

  // msb first, then releases data for the ack clock
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sl(1'b0, !b[i]);
      sl(1'b1, !b[i]);
    end
    sl(1'b0, 1'b0);
    sl(1'b1, 1'b0);
    ack = !sda;
  endtask

  task automatic recv(input logic nack, output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      sl(1'b0, 1'b0);
      sl(1'b1, 1'b0);
      d = {d[6:0], sda};
    end
    sl(1'b0, !nack);
    sl(1'b1, !nack);
  endtask
endmodule

//--- cbr_monitor.sv
// port checker for the configuration bank smbus target
// assumes it is bound to cbr_top
`timescale 1ns/1ps
module cbr_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic feedback_edge_rate_select,
  input wire logic [4:0] read_length
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_feedback_reset: assert property ($rose(rst_b) |-> feedback_edge_rate_select)
    else $error("feedback select not fast after reset");
  a_len_reset: assert property ($rose(rst_b) |-> read_length == 5'h08)
    else $error("read length not 8 after reset");
  a_oe_reset: assert property ($rose(rst_b) |-> !sda_oe)
    else $error("data driven after reset");
  a_ack_after_fall: assert property ($rose(sda_oe) |-> $past(scl_in, 2) && !$past(scl_in))
    else $error("data drive not after clock fall");
  a_drive_holds: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data drive too short");
  a_quiet_high: assert property ((scl_in && $stable(sda_in)) [*3] |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  a_feedback_on_bus: assert property ($changed(feedback_edge_rate_select) |-> !scl_in)
    else $error("feedback select changed outside a byte");
  a_len_on_bus: assert property ($changed(read_length) |-> !scl_in)
    else $error("read length changed outside a byte");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data output not low");

  c_ack: cover property ($rose(sda_oe));
  c_feedback_slow: cover property ($fell(feedback_edge_rate_select));
  c_len: cover property ($changed(read_length));
endmodule

bind cbr_top cbr_monitor u_mon (.clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .feedback_edge_rate_select(feedback_edge_rate_select),
  .read_length(read_length));

//--- tb.sv
// testbench for the configuration bank through block reads and writes
// assumes default identity parameters of cbr_top
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst_b;
  logic scl;
  logic sda;
  logic sda_oe;
  logic feedback_sel;
  logic [4:0] rd_len;
  logic ack;
  int err_total;
  int cmp_count;

  cbr_top dut (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .feedback_edge_rate_select(feedback_sel), .read_length(rd_len));
  cbr_host host (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic test_done;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_regs(input logic [7:0] idx, input int n, input logic [31:0] d);
    host.start();
    host.send({cbr_pkg::SMB_ADDR_DEFAULT, 1'b0}, ack);
    chk8("write addr ack", 8'h01, {7'h0, ack});
    host.send(idx, ack);
    chk8("index ack", 8'h01, {7'h0, ack});
    host.send(n[7:0], ack);
    chk8("count ack", 8'h01, {7'h0, ack});
    for (int i = 0; i < n; i++) begin
      host.send(d[31-8*i -: 8], ack);
      chk8("data ack", 8'h01, {7'h0, ack});
    end
    host.stop();
  endtask

  // e holds the count byte first, then the data bytes
  task automatic rd_regs(input logic [7:0] idx, input int n, input logic [47:0] e);
    logic [7:0] b;
    host.start();
    host.send({cbr_pkg::SMB_ADDR_DEFAULT, 1'b0}, ack);
    host.send(idx, ack);
    host.start();
    host.send({cbr_pkg::SMB_ADDR_DEFAULT, 1'b1}, ack);
    chk8("read addr ack", 8'h01, {7'h0, ack});
    for (int i = 0; i < n; i++) begin
      host.recv(i == n - 1, b);
      chk8("read byte", e[47-8*i -: 8], b);
    end
    host.stop();
  endtask

  task automatic t_reset;
    chk8("feedback select", 8'h01, {7'h0, feedback_sel});
    chk8("read length", 8'h08, {3'h0, rd_len});
  endtask

  task automatic t_ident;
    rd_regs(8'h03, 6, {8'h08, 8'h83, 8'hff, 8'h39, 8'h95, 8'h08});
  endtask

  task automatic t_ro_write;
    wr_regs(8'h03, 4, 32'h0);
    chk8("feedback select", 8'h00, {7'h0, feedback_sel});
    rd_regs(8'h03, 5, {8'h08, 8'h82, 8'hff, 8'h39, 8'h95, 8'h00});
  endtask

  task automatic t_len;
    wr_regs(8'h07, 1, 32'he3000000);
    chk8("read length", 8'h03, {3'h0, rd_len});
    rd_regs(8'h05, 5, {8'h03, 8'h39, 8'h95, 8'h03, 8'hff, 8'h00});
    wr_regs(8'h03, 1, 32'h01000000);
    chk8("feedback select", 8'h01, {7'h0, feedback_sel});
  endtask

  task automatic t_refuse;
    host.start();
    host.send({cbr_pkg::SMB_ADDR_DEFAULT ^ 7'h01, 1'b0}, ack);
    chk8("foreign addr ack", 8'h00, {7'h0, ack});
    host.stop();
    // count of one: a second data byte is refused and not written
    host.start();
    host.send({cbr_pkg::SMB_ADDR_DEFAULT, 1'b0}, ack);
    host.send(8'h06, ack);
    host.send(8'h01, ack);
    host.send(8'h00, ack);
    chk8("counted byte ack", 8'h01, {7'h0, ack});
    host.send(8'h1e, ack);
    chk8("extra byte ack", 8'h00, {7'h0, ack});
    host.stop();
    chk8("read length", 8'h03, {3'h0, rd_len});
  endtask

  // mid-run reset returns the written length to its default
  task automatic t_rerst;
    wr_regs(8'h07, 1, 32'h1f000000);
    chk8("read length", 8'h1f, {3'h0, rd_len});
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    rd_regs(8'h07, 3, {8'h08, 8'h08, 8'h00, 24'h0});
  endtask

  initial begin
    err_total = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_ident();
    t_ro_write();
    t_len();
    t_refuse();
    t_rerst();
    test_done();
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
